/* rtl/ddssp_pkg.sv */
package ddssp_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CONFIG_REG_ONE_ADDR  = 8'h00;
   localparam logic [7:0] CONFIG_REG_TWO_ADDR  = 8'h01;
   localparam logic [7:0] CONFIG_REG_FOUR_ADDR = 8'h03;
   localparam logic [7:0] FREQ_WORD_ADDR       = 8'h04;
   localparam logic [7:0] MOD_B_ADDR           = 8'h05;
   localparam logic [7:0] MOD_A_ADDR           = 8'h06;
   localparam logic [7:0] RAMP_CFG_ADDR        = 8'h07;
   localparam logic [7:0] RAMP_VALUE_ADDR      = 8'h08;
   localparam logic [7:0] STATUS_ADDR          = 8'h09;
   localparam logic [7:0] PROFILE_BASE_ADDR    = 8'h10;
   localparam logic [7:0] PROFILE_AMP_BASE     = 8'h18;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int OSK_ENABLE_BIT   = 8;
   localparam int SINE_SELECT_BIT  = 16;
   localparam int PROFILE_EN_BIT   = 23;
   localparam int PARALLEL_EN_BIT  = 22;
   localparam int MODULUS_EN_BIT   = 0;
   localparam int DAC_CAL_BIT      = 24;
   localparam int RAMP_EN_BIT      = 19;
   localparam int RAMP_DEST_LSB    = 20;
   localparam int PAR_DEST_LSB     = 1;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [31:0] CONFIG_REG_ONE_RST = 32'h0001_0000;
   localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;
   localparam logic [11:0] AMP_FULL           = 12'hFFF;
   localparam int          UPDATE_DIVIDE      = 24;
   localparam int          CAL_SAMPLE_PERIODS = 469632;
   localparam int          CLOCK_PERIOD_NS    = 100;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      DDSSP_DEST_FREQ  = 2'h0,
      DDSSP_DEST_PHASE = 2'h1,
      DDSSP_DEST_AMP   = 2'h2
   } ddssp_dest_t;
   typedef enum logic [1:0] {
      DDSSP_CAL_IDLE = 2'b01,
      DDSSP_CAL_RUN  = 2'b10
   } ddssp_cal_t;
endpackage : ddssp_pkg

/* rtl/ddssp_core.sv */
`timescale 1ns/10ps
module ddssp_core
   import ddssp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] freq_word,
   input  wire logic [15:0] phase_offset_word,
   input  wire logic [11:0] amp_scale_factor,
   input  wire logic        modulus_en,
   input  wire logic [31:0] mod_a,
   input  wire logic [31:0] mod_b,
   input  wire logic        sine_sel,
   output logic      [11:0] sample_q
);
   logic [31:0] phase_acc_q;
   logic [31:0] aux_acc_q;
   logic        aux_carry;
   logic [32:0] aux_sum;
   logic [15:0] phase_sum;
   logic [13:0] lut_phase;
   logic signed [11:0] wave;
   logic signed [24:0] scaled;

   // ----------------------------------------
   // Auxiliary modulus accumulator
   // ----------------------------------------
   assign aux_sum   = {1'b0, aux_acc_q} + {1'b0, mod_a};
   assign aux_carry = modulus_en && (aux_sum >= {1'b0, mod_b});

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_acc_q <= 32'h0000_0000;
      end else if (!modulus_en) begin
         aux_acc_q <= 32'h0000_0000;
      end else if (aux_carry) begin
         aux_acc_q <= 32'(aux_sum - {1'b0, mod_b});
      end else begin
         aux_acc_q <= aux_sum[31:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_acc_q <= 32'h0000_0000;
      end else begin
         phase_acc_q <= phase_acc_q + freq_word + {31'h0, aux_carry};
      end
   end

   // ----------------------------------------
   // Angle to amplitude and scaling
   // ----------------------------------------
   assign phase_sum = phase_acc_q[31:16] + phase_offset_word;
   // Cosine is the sine shifted by a quarter turn.
   assign lut_phase = sine_sel ? phase_sum[15:2] : 14'(phase_sum[15:2] + 14'h1000);

   // A parabolic approximation keeps area small at some cost in purity.
   function automatic logic signed [11:0] sin_approx(input logic [13:0] p);
      logic [12:0] x;
      logic [25:0] sq;
      logic [12:0] mag;
      x   = p[12:0];
      sq  = 26'(x) * 26'(13'h1FFF - x);
      mag = sq[24:12];
      sin_approx = p[13] ? -$signed({1'b0, mag[12:2]}) : $signed({1'b0, mag[12:2]});
   endfunction : sin_approx

   assign wave   = sin_approx(lut_phase);
   assign scaled = wave * $signed({1'b0, amp_scale_factor});

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_q <= 12'h800;
      end else begin
         sample_q <= {~scaled[23], scaled[22:12]};
      end
   end
endmodule : ddssp_core

/* rtl/ddssp_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Precedence: modulus, ramp, profiles, parallel port.
// - Profile beats parallel port on frequency.
// - Modulus locks frequency; ramp sweeps unavailable.
// - Profile amplitude only with shift keying enabled.
// - Profiles drive parameters the ramp leaves.
// - Profiles set all three parameters independently.
// - Sine when select bit set, else cosine.
// - Accumulator adds frequency word every cycle.
// - Sixteen-bit phase offset added before conversion.
// - Amplitude factor scales converter output by /4096.
// - Parameters update at most every 24 cycles.
// - Calibration runs 469632 sample periods.
// - Twelve-bit samples each system clock.
// - Update enable divides by 24; pins sampled there.
// - Eight profiles chosen by select pins.
// - Modulus rollover adds one phase LSB.
// - Shift keying enable at config bit 8.
module ddssp_top
   import ddssp_pkg::*;
#(
   parameter int CAL_CYCLES = CAL_SAMPLE_PERIODS
)(
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic [2:0]  PROFILE_SELECT_PINS,
   input  wire logic        RAMP_DIRECTION_PIN,
   input  wire logic        RAMP_HOLD_PIN,
   input  wire logic [31:0] PAR_DATA,
   output logic      [11:0] DAC_SAMPLE,
   output logic             CAL_BUSY,
   output logic             UPDATE_TICK
);
   import ddssp_pkg::*;

   logic        rst_s1_q;
   logic        rst_n;
   logic [31:0] config_reg_one_q;
   logic [31:0] config_reg_two_q;
   logic [31:0] config_reg_four_q;
   logic [31:0] freq_reg_q;
   logic [31:0] mod_a_q;
   logic [31:0] mod_b_q;
   logic [31:0] ramp_cfg_q;
   logic [31:0] ramp_q;
   logic [31:0] prof_ftw_q [8];
   logic [31:0] prof_pa_q  [8];
   logic [4:0]  div_q;
   logic        tick;
   logic [2:0]  psel_q;
   logic        rdir_q;
   logic        rhold_q;
   logic [31:0] par_q;
   logic [31:0] ftw_q;
   logic [15:0] pow_q;
   logic [11:0] asf_q;
   logic [31:0] ftw_d;
   logic [15:0] pow_d;
   logic [11:0] asf_d;
   logic        cal_bit_last_q;
   logic [19:0] cal_cnt_q;
   ddssp_cal_t  cal_state_q;
   logic [11:0] sample;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         config_reg_one_q  <= CONFIG_REG_ONE_RST;
         config_reg_two_q  <= ZERO_WORD;
         config_reg_four_q <= ZERO_WORD;
         freq_reg_q        <= ZERO_WORD;
         mod_a_q           <= ZERO_WORD;
         mod_b_q           <= ZERO_WORD;
         ramp_cfg_q        <= ZERO_WORD;
         for (int i = 0; i < 8; i++) begin
            prof_ftw_q[i] <= ZERO_WORD;
            prof_pa_q[i]  <= ZERO_WORD;
         end
      end else if (WR) begin
         unique case (ADDR)
            CONFIG_REG_ONE_ADDR:  config_reg_one_q  <= WDATA;
            CONFIG_REG_TWO_ADDR:  config_reg_two_q  <= WDATA;
            CONFIG_REG_FOUR_ADDR: config_reg_four_q <= WDATA;
            FREQ_WORD_ADDR:       freq_reg_q        <= WDATA;
            MOD_B_ADDR:           mod_b_q           <= WDATA;
            MOD_A_ADDR:           mod_a_q           <= WDATA;
            RAMP_CFG_ADDR:        ramp_cfg_q        <= WDATA;
            default: begin
               if (ADDR[7:3] == PROFILE_BASE_ADDR[7:3]) begin
                  prof_ftw_q[ADDR[2:0]] <= WDATA;
               end else if (ADDR[7:3] == PROFILE_AMP_BASE[7:3]) begin
                  prof_pa_q[ADDR[2:0]] <= WDATA;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Update enable and pin sampling
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 5'h00;
      end else if (div_q == 5'(UPDATE_DIVIDE - 1)) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end
   assign tick = (div_q == 5'(UPDATE_DIVIDE - 1));

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         psel_q  <= 3'h0;
         rdir_q  <= 1'b0;
         rhold_q <= 1'b0;
         par_q   <= ZERO_WORD;
      end else if (tick) begin
         psel_q  <= PROFILE_SELECT_PINS;
         rdir_q  <= RAMP_DIRECTION_PIN;
         rhold_q <= RAMP_HOLD_PIN;
         par_q   <= PAR_DATA;
      end
   end

   // ----------------------------------------
   // Simple ramp sweep
   // ----------------------------------------
   // The sweep is a plain up/down step; limits are left to software.
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ramp_q <= ZERO_WORD;
      end else if (WR && ADDR == RAMP_VALUE_ADDR) begin
         ramp_q <= WDATA;
      end else if (tick && ramp_cfg_q[RAMP_EN_BIT] && !rhold_q) begin
         ramp_q <= rdir_q ? ramp_q + {16'h0000, ramp_cfg_q[15:0]}
                          : ramp_q - {16'h0000, ramp_cfg_q[15:0]};
      end
   end

   // ----------------------------------------
   // Source priority
   // ----------------------------------------
   always_comb begin
      logic        mod_on;
      logic        ramp_on;
      logic        prof_on;
      logic        par_on;
      ddssp_dest_t rdest;
      ddssp_dest_t pdest;
      mod_on  = config_reg_two_q[MODULUS_EN_BIT];
      ramp_on = ramp_cfg_q[RAMP_EN_BIT] && !mod_on;
      prof_on = config_reg_two_q[PROFILE_EN_BIT];
      par_on  = config_reg_two_q[PARALLEL_EN_BIT];
      rdest   = ddssp_dest_t'(ramp_cfg_q[RAMP_DEST_LSB +: 2]);
      pdest   = ddssp_dest_t'(config_reg_two_q[PAR_DEST_LSB +: 2]);
      // Each parameter resolves on its own.
      ftw_d = freq_reg_q;
      if (mod_on) begin
         ftw_d = freq_reg_q;
      end else if (ramp_on && rdest == DDSSP_DEST_FREQ) begin
         ftw_d = ramp_q;
      end else if (prof_on) begin
         ftw_d = prof_ftw_q[psel_q];
      end else if (par_on && pdest == DDSSP_DEST_FREQ) begin
         ftw_d = par_q;
      end
      pow_d = 16'h0000;
      if (ramp_on && rdest == DDSSP_DEST_PHASE) begin
         pow_d = ramp_q[15:0];
      end else if (prof_on) begin
         pow_d = prof_pa_q[psel_q][15:0];
      end else if (par_on && pdest == DDSSP_DEST_PHASE) begin
         pow_d = par_q[15:0];
      end
      asf_d = AMP_FULL;
      if (config_reg_one_q[OSK_ENABLE_BIT]) begin
         if (ramp_on && rdest == DDSSP_DEST_AMP) begin
            asf_d = ramp_q[11:0];
         end else if (prof_on) begin
            asf_d = prof_pa_q[psel_q][27:16];
         end else if (par_on && pdest == DDSSP_DEST_AMP) begin
            asf_d = par_q[11:0];
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ftw_q <= ZERO_WORD;
         pow_q <= 16'h0000;
         asf_q <= AMP_FULL;
      end else if (tick) begin
         ftw_q <= ftw_d;
         pow_q <= pow_d;
         asf_q <= asf_d;
      end
   end

   // ----------------------------------------
   // Converter calibration
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cal_bit_last_q <= 1'b0;
         cal_cnt_q      <= 20'h00000;
         cal_state_q    <= DDSSP_CAL_IDLE;
      end else begin
         cal_bit_last_q <= config_reg_four_q[DAC_CAL_BIT];
         unique case (cal_state_q)
            DDSSP_CAL_IDLE: begin
               if (config_reg_four_q[DAC_CAL_BIT] && !cal_bit_last_q) begin
                  cal_cnt_q   <= 20'(CAL_CYCLES - 1);
                  cal_state_q <= DDSSP_CAL_RUN;
               end
            end
            DDSSP_CAL_RUN: begin
               if (cal_cnt_q == 20'h00000) begin
                  cal_state_q <= DDSSP_CAL_IDLE;
               end else begin
                  cal_cnt_q <= cal_cnt_q - 20'h00001;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Core and outputs
   // ----------------------------------------
   ddssp_core u_core (
      .clk               (REF_CLK),
      .rst_n             (rst_n),
      .freq_word         (ftw_q),
      .phase_offset_word (pow_q),
      .amp_scale_factor  (asf_q),
      .modulus_en        (config_reg_two_q[MODULUS_EN_BIT]),
      .mod_a             (mod_a_q),
      .mod_b             (mod_b_q),
      .sine_sel          (config_reg_one_q[SINE_SELECT_BIT]),
      .sample_q          (sample)
   );

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         DAC_SAMPLE  <= 12'h800;
         CAL_BUSY    <= 1'b0;
         UPDATE_TICK <= 1'b0;
      end else begin
         DAC_SAMPLE  <= sample;
         CAL_BUSY    <= (cal_state_q == DDSSP_CAL_RUN);
         UPDATE_TICK <= tick;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= ZERO_WORD;
      end else if (RD) begin
         unique case (ADDR)
            CONFIG_REG_ONE_ADDR:  RDATA <= config_reg_one_q;
            CONFIG_REG_TWO_ADDR:  RDATA <= config_reg_two_q;
            CONFIG_REG_FOUR_ADDR: RDATA <= config_reg_four_q;
            FREQ_WORD_ADDR:       RDATA <= freq_reg_q;
            MOD_B_ADDR:           RDATA <= mod_b_q;
            MOD_A_ADDR:           RDATA <= mod_a_q;
            RAMP_CFG_ADDR:        RDATA <= ramp_cfg_q;
            RAMP_VALUE_ADDR:      RDATA <= ramp_q;
            STATUS_ADDR:          RDATA <= {19'h00000, (cal_state_q == DDSSP_CAL_RUN), asf_q};
            default: begin
               if (ADDR[7:3] == PROFILE_BASE_ADDR[7:3]) begin
                  RDATA <= prof_ftw_q[ADDR[2:0]];
               end else if (ADDR[7:3] == PROFILE_AMP_BASE[7:3]) begin
                  RDATA <= prof_pa_q[ADDR[2:0]];
               end else begin
                  RDATA <= ZERO_WORD;
               end
            end
         endcase
      end else begin
         RDATA <= ZERO_WORD;
      end
   end
endmodule : ddssp_top

/* dv/ddssp_properties.sv */
`timescale 1ns/10ps
module ddssp_chk
   import ddssp_pkg::*;
#(
   parameter int CAL_CYCLES = CAL_SAMPLE_PERIODS
)(
   input wire logic        REF_CLK,
   input wire logic        NRST,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic        CAL_BUSY,
   input wire logic        UPDATE_TICK
);
   // ----------------
   // Helper logic
   // ----------------
   logic [4:0]  gap_q;
   logic        seen_q;
   logic [31:0] busy_len_q;
   logic        cal_bit_q;
   logic        cal_wr;
   assign cal_wr = WR && (ADDR == CONFIG_REG_FOUR_ADDR) && WDATA[DAC_CAL_BIT];
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         gap_q  <= 5'h00;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= UPDATE_TICK ? 5'h00 : gap_q + 5'h01;
         seen_q <= seen_q | UPDATE_TICK;
      end
   end
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         busy_len_q <= 32'h0;
      end else begin
         busy_len_q <= CAL_BUSY ? busy_len_q + 32'h1 : 32'h0;
      end
   end
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         cal_bit_q <= 1'b0;
      end else if (WR && ADDR == CONFIG_REG_FOUR_ADDR) begin
         cal_bit_q <= WDATA[DAC_CAL_BIT];
      end
   end
   // ----------------
   // Assertions
   // ----------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   AST_TICK_PERIOD: assert property (seen_q |-> (UPDATE_TICK == (gap_q == 5'h17)))
      else $error("Update tick spacing is not 24 cycles.");
   AST_TICK_PULSE: assert property (UPDATE_TICK |=> !UPDATE_TICK)
      else $error("Update tick longer than one cycle.");
   AST_CAL_START: assert property (cal_wr && !cal_bit_q && !CAL_BUSY |-> ##3 CAL_BUSY)
      else $error("Calibration did not start.");
   AST_CAL_CAUSE: assert property ($rose(CAL_BUSY) |-> $past(cal_wr, 3))
      else $error("Calibration started without request.");
   AST_CAL_HOLD: assert property ($rose(CAL_BUSY) |=> CAL_BUSY [*8])
      else $error("Calibration ended early.");
   AST_CAL_LEN: assert property ($fell(CAL_BUSY) |-> busy_len_q == CAL_CYCLES)
      else $error("Calibration length wrong.");
   AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("Read data outside read slot.");
   AST_RD_UNMAPPED: assert property (RD && ADDR >= 8'h20 |=> RDATA == 32'h0)
      else $error("Unmapped read not zero.");
   // The status bit and the busy pin both copy the same state one edge later, so they agree.
   AST_STATUS_BUSY: assert property (RD && ADDR == STATUS_ADDR |=> RDATA[12] == CAL_BUSY)
      else $error("Status busy bit disagrees with calibration state.");
endmodule : ddssp_chk

bind ddssp_top ddssp_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.REF_CLK(REF_CLK), .NRST(NRST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CAL_BUSY(CAL_BUSY),
   .UPDATE_TICK(UPDATE_TICK));

/* dv/ddssp_dac_model.sv */
`timescale 1ns/10ps
module ddssp_dac_model (
   input  wire logic [11:0] sample,
   input  wire logic        clk,
   output int               changes
);
   logic [11:0] last_q  = 12'h800;
   int          count_q = 0;
   assign changes = count_q;
   // The converter takes a new code every clock, so a stuck sample shows as no change.
   always @(posedge clk) begin
      if (sample !== last_q) begin
         count_q <= count_q + 1;
      end
      last_q <= sample;
   end
endmodule : ddssp_dac_model

/* dv/testbench.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench;
   import ddssp_pkg::*;
   localparam int CAL = 20;
   logic        REF_CLK = 1'b0;
   logic        NRST = 1'b0;
   logic [7:0]  ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic [2:0]  PROFILE_SELECT_PINS = 3'h0;
   logic        RAMP_DIRECTION_PIN = 1'b0;
   logic        RAMP_HOLD_PIN = 1'b1;
   logic [31:0] PAR_DATA = 32'h0;
   logic [31:0] RDATA;
   logic [11:0] DAC_SAMPLE;
   logic        CAL_BUSY;
   logic        UPDATE_TICK;
   int          fail_count = 0;
   int          compares = 0;
   int          busy_n = 0;
   int          seed = 32'h81c2;
   int          changes;
   int          c0;
   logic        rd_p = 1'b0;
   logic [31:0] ex_q[$];
   logic [31:0] mk_q[$];
   logic [31:0] pa[8];
   logic [31:0] f;
   logic [31:0] rv;
   logic [31:0] e;
   logic [31:0] m;
   logic [11:0] s_sin;
   always #50 REF_CLK = ~REF_CLK;
   ddssp_top #(.CAL_CYCLES(CAL)) u_dut (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .PROFILE_SELECT_PINS(PROFILE_SELECT_PINS), .RAMP_DIRECTION_PIN(RAMP_DIRECTION_PIN),
      .RAMP_HOLD_PIN(RAMP_HOLD_PIN), .PAR_DATA(PAR_DATA), .DAC_SAMPLE(DAC_SAMPLE),
      .CAL_BUSY(CAL_BUSY), .UPDATE_TICK(UPDATE_TICK));
   ddssp_dac_model u_dac (.sample(DAC_SAMPLE), .clk(REF_CLK), .changes(changes));
   // ----------------
   // Bus tasks
   // ----------------
   task bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      WR <= w;
      RD <= r;
      ADDR <= a;
      WDATA <= d;
      @(posedge REF_CLK);
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
      ex_q.push_back(x & k);
      mk_q.push_back(k);
      bus(1'b0, 1'b1, a, 32'h0);
   endtask : rd
   // Parameters move only on ticks, so waits are counted in ticks.
   task tk(input int n);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      repeat (n) @(posedge REF_CLK iff UPDATE_TICK);
   endtask : tk
   task stop_test();
      $display("Compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // ----------------
   // Checking
   // ----------------
   always @(posedge REF_CLK) begin
      if (rd_p) begin
         e = ex_q.pop_front();
         m = mk_q.pop_front();
         `CHK("RDATA", e, RDATA & m)
      end
      rd_p <= RD;
   end
   always @(posedge REF_CLK) if (CAL_BUSY === 1'b1) busy_n++;
   initial begin
      #(20000 * CLOCK_PERIOD_NS);
      fail_count++;
      stop_test();
   end
   initial begin
      for (int k = 0; k < 8; k++) pa[k] = $random(seed);
      repeat (10) @(posedge REF_CLK);
      NRST <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      rd(CONFIG_REG_ONE_ADDR, CONFIG_REG_ONE_RST, 32'hFFFF_FFFF);
      rd(CONFIG_REG_TWO_ADDR, ZERO_WORD, 32'hFFFF_FFFF);
      rd(8'h20, ZERO_WORD, 32'hFFFF_FFFF);
      rd(STATUS_ADDR, 32'hFFF, 32'h1FFF);
      f = $random(seed) & 32'h7FFF_FFFF;
      wr(FREQ_WORD_ADDR, f);
      rd(FREQ_WORD_ADDR, f, 32'hFFFF_FFFF);
      for (int k = 0; k < 8; k++) wr(PROFILE_AMP_BASE + 8'(k), pa[k]);
      wr(CONFIG_REG_TWO_ADDR, 32'h0080_0000);
      tk(3);
      rd(STATUS_ADDR, 32'hFFF, 32'hFFF);
      wr(CONFIG_REG_ONE_ADDR, 32'h0001_0100);
      for (int k = 0; k < 8; k++) begin
         PROFILE_SELECT_PINS <= 3'(k);
         tk(3);
         rd(STATUS_ADDR, pa[k] >> 16, 32'hFFF);
      end
      PAR_DATA <= $random(seed);
      wr(CONFIG_REG_TWO_ADDR, 32'h00C0_0004);
      tk(3);
      rd(STATUS_ADDR, pa[7] >> 16, 32'hFFF);
      wr(CONFIG_REG_TWO_ADDR, 32'h0040_0004);
      tk(3);
      rd(STATUS_ADDR, PAR_DATA, 32'hFFF);
      rv = $random(seed);
      wr(RAMP_VALUE_ADDR, rv);
      wr(RAMP_CFG_ADDR, 32'h0028_0010);
      wr(CONFIG_REG_TWO_ADDR, 32'h0080_0000);
      tk(3);
      rd(STATUS_ADDR, rv, 32'hFFF);
      // Hold is released for exactly one sampling tick, so the ramp takes one upward step.
      RAMP_DIRECTION_PIN <= 1'b1;
      RAMP_HOLD_PIN <= 1'b0;
      tk(1);
      RAMP_HOLD_PIN <= 1'b1;
      tk(3);
      rd(RAMP_VALUE_ADDR, rv + 32'h10, 32'hFFFF_FFFF);
      wr(MOD_B_ADDR, 32'h0000_0005);
      wr(MOD_A_ADDR, 32'h0000_0004);
      wr(CONFIG_REG_TWO_ADDR, 32'h0080_0001);
      tk(3);
      rd(STATUS_ADDR, pa[7] >> 16, 32'hFFF);
      wr(RAMP_CFG_ADDR, ZERO_WORD);
      wr(CONFIG_REG_TWO_ADDR, ZERO_WORD);
      wr(FREQ_WORD_ADDR, ZERO_WORD);
      wr(CONFIG_REG_ONE_ADDR, 32'h0001_0000);
      tk(2);
      c0 = changes;
      repeat (30) @(posedge REF_CLK);
      s_sin = DAC_SAMPLE;
      `CHK("dac still", c0, changes)
      wr(CONFIG_REG_ONE_ADDR, ZERO_WORD);
      tk(2);
      `CHK("cosine", 1'b1, DAC_SAMPLE !== s_sin)
      wr(FREQ_WORD_ADDR, 32'h0800_0000);
      tk(1);
      c0 = changes;
      repeat (16) @(posedge REF_CLK);
      `CHK("dac moving", 1'b1, (changes - c0) > 8)
      busy_n = 0;
      wr(CONFIG_REG_FOUR_ADDR, 32'h0100_0000);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      bus(1'b0, 1'b0, 8'h00, 32'h0);
      rd(STATUS_ADDR, 32'h1000, 32'h1000);
      tk(3);
      `CHK("cal length", CAL, busy_n)
      wr(CONFIG_REG_FOUR_ADDR, ZERO_WORD);
      tk(1);
      stop_test();
   end
endmodule : testbench
